// >>> inc/arp_pkg.sv
package arp_pkg;
   // channel count and counter width
   localparam int ARP_CHANNELS = 4;
   localparam int ARP_WIDTH = 8;
   // values after reset, and the counter's terminal count
   localparam logic [7:0] ARP_RELOAD_RST = 8'h00;
   localparam logic [7:0] ARP_DUTY_RST = 8'h00;
   localparam logic [7:0] ARP_COUNT_RST = 8'h00;
   localparam logic [7:0] ARP_COUNT_MAX = 8'hff;
   // counter clock source selection
   typedef enum logic {
      ARP_SRC_INTERNAL,
      ARP_SRC_EXTERNAL
   } arp_src_e;
endpackage

// >>> inc/arp_tick_if.sv
interface arp_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface

// >>> core/arp_tick_gen.sv
module arp_tick_gen
   import arp_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ext_clk_i,
   input wire logic ext_mode_i,
   input wire logic run_i,
   arp_tick_if.src tick_if
);
   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;

   // two-stage synchroniser for the external count clock
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         sync1_reg <= ext_clk_i;
         sync2_reg <= sync1_reg;
         last_reg <= sync2_reg;
      end
   end

   // count tick while running: every cycle internally, rising edge externally
   assign tick_if.tick = run_i & (ext_mode_i ? (sync2_reg & ~last_reg) : 1'b1);
endmodule

// >>> core/arp_pwm_timer.sv
// Function
// R01: four independent pwm outputs; all generation stops while halt is asserted.
// R02: each channel has an output enable; enabled pins drive push-pull.
// R03: pwm frequency equals counter clock divided by 256 minus reload value.
// R04: on overflow each active pin takes the level set by its polarity.
// R05: counter matching a channel's compare value restores the pin's earlier level.
// R06: software loads compare values above the reload value to obtain a waveform.
// R07: reload zero gives 1/256 resolution; 0% and 100% through polarity.
// R08: overflow sets the flag; interrupt requested only when enabled.
// R09: flag stays set until software clears it, which software must do.
// R10: event mode counts external clock edges; flag after 256 minus reload events.
// R11: software clears counter enable before halt to avoid spurious counts.
// R12: counter counts up to ffh, then overflows and reloads from reload value.
module arp_pwm_timer
   import arp_pkg::*;
#(
   parameter int CHANNELS = ARP_CHANNELS
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic halt_i,
   input wire logic external_count_clock_i,
   input wire logic event_mode_i,
   input wire logic counter_enable_i,
   input wire logic overflow_irq_enable_i,
   input wire logic overflow_flag_clear_i,
   input wire logic [7:0] reload_value_reg_i,
   input wire logic [CHANNELS-1:0] pwm_output_enable_i,
   input wire logic [CHANNELS-1:0] pwm_output_polarity_i,
   input wire logic [CHANNELS*8-1:0] duty_compare_reg_i,
   output logic [CHANNELS-1:0] pwm_output_pin_o,
   output logic [CHANNELS-1:0] pwm_output_pin_oe_o,
   output logic overflow_flag_o,
   output logic overflow_irq_o,
   output logic [7:0] counter_o
);
   // counter clock source as selected by the mode input
   arp_src_e src_sel;

   // external source chosen
   logic ext_sel;

   // tick carrier between the tick source and the counter
   arp_tick_if tick_bus ();

   // counting permission after halt and enable gating
   logic run;

   // counter state and its next value
   logic [7:0] count_reg;
   logic [7:0] count_next;

   // terminal count reached, and a tick arriving on it
   logic at_max;
   logic overflow;

   // sticky overflow flag and its next value
   logic ovf_reg;
   logic ovf_next;

   // per-channel pin and driver levels gathered from the loop
   wire logic [CHANNELS-1:0] pin_level;
   wire logic [CHANNELS-1:0] drive_level;

   // counting halts during halt and while disabled
   assign run = counter_enable_i & ~halt_i; // [R01] [R11]

   // mode input mapped onto the source type
   assign src_sel = event_mode_i ? ARP_SRC_EXTERNAL : ARP_SRC_INTERNAL; // [R10]

   // external edges only count in event mode
   assign ext_sel = (src_sel == ARP_SRC_EXTERNAL); // [R10]

   // tick source: internal clock or synchronised external edges
   arp_tick_gen u_tick (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ext_clk_i(external_count_clock_i),
      .ext_mode_i(ext_sel), // [R10]
      .run_i(run),
      .tick_if(tick_bus.src)
   );

   // terminal count detection
   assign at_max = (count_reg == ARP_COUNT_MAX); // [R12]

   // overflow when a tick arrives at ffh
   assign overflow = tick_bus.tick & at_max; // [R08] [R12]

   // next counter value: reload on overflow, otherwise step up
   always_comb begin
      if (overflow) begin
         count_next = reload_value_reg_i; // [R03] [R10] [R12]
      end else begin
         count_next = count_reg + 8'h01; // [R12]
      end
   end

   // auto-reload counter, frozen between ticks
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_reg <= ARP_COUNT_RST;
      end else if (tick_bus.tick) begin
         count_reg <= count_next;
      end
   end

   // flag next value: set wins over a clear in the same cycle
   always_comb begin
      case ({overflow, overflow_flag_clear_i})
         2'b10, 2'b11: begin
            ovf_next = 1'b1; // [R08]
         end
         2'b01: begin
            ovf_next = 1'b0; // [R09]
         end
         default: begin
            ovf_next = ovf_reg; // [R09]
         end
      endcase
   end

   // sticky overflow flag
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ovf_reg <= 1'b0;
      end else begin
         ovf_reg <= ovf_next;
      end
   end

   // per-channel pwm: raw level, polarity, enable and pin registers
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         // this channel's compare value
         logic [7:0] duty;
         // compare hit on the value the counter is about to take
         logic match;
         // raw level: high from overflow up to the compare hit
         logic raw_reg;
         logic raw_next;
         // pin level after polarity and enable
         logic pin_reg;
         logic pin_next;
         // driver enable copy
         logic oe_reg;

         // this channel's slice of the compare bus
         assign duty = duty_compare_reg_i[g*8 +: 8];

         // a match only counts when a tick really moves the counter
         assign match = tick_bus.tick & (count_next == duty); // [R05]

         // overflow sets the raw level, a later match restores it
         always_comb begin
            case ({overflow, match})
               2'b10, 2'b11: begin
                  raw_next = 1'b1; // [R04]
               end
               2'b01: begin
                  raw_next = 1'b0; // [R05]
               end
               default: begin
                  raw_next = raw_reg;
               end
            endcase
         end

         // raw level register
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               raw_reg <= 1'b0;
            end else begin
               raw_reg <= raw_next;
            end
         end

         // polarity flips the level, a disabled channel drives low
         always_comb begin
            if (pwm_output_enable_i[g]) begin
               pin_next = raw_reg ^ pwm_output_polarity_i[g]; // [R04]
            end else begin
               pin_next = 1'b0; // [R02]
            end
         end

         // pin register
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               pin_reg <= 1'b0;
            end else begin
               pin_reg <= pin_next;
            end
         end

         // push-pull driver enable follows the channel enable
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               oe_reg <= 1'b0;
            end else begin
               oe_reg <= pwm_output_enable_i[g]; // [R02]
            end
         end

         // hand the channel levels to the shared vectors
         assign pin_level[g] = pin_reg;
         assign drive_level[g] = oe_reg;
      end
   endgenerate

   // pin outputs and their driver enables
   assign pwm_output_pin_o = pin_level; // [R01]
   assign pwm_output_pin_oe_o = drive_level; // [R02]

   // flag and interrupt request
   assign overflow_flag_o = ovf_reg;
   assign overflow_irq_o = ovf_reg & overflow_irq_enable_i; // [R08]

   // counter value for observation
   assign counter_o = count_reg;
endmodule

// >>> sim/arp_load_model.sv
module arp_load_model (
   input wire logic [3:0] pin_i,
   input wire logic [3:0] oe_i,
   output logic [3:0] level_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign level_o = pin_i & oe_i; // pulled low when not driven
endmodule

// >>> sim/arp_pwm_timer_props.sv
module arp_pwm_timer_props (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic halt_i,
   input wire logic counter_enable_i,
   input wire logic overflow_irq_enable_i,
   input wire logic overflow_flag_clear_i,
   input wire logic [7:0] reload_value_reg_i,
   input wire logic [3:0] pwm_output_enable_i,
   input wire logic [3:0] pwm_output_polarity_i,
   input wire logic [3:0] pwm_output_pin_o,
   input wire logic [3:0] pwm_output_pin_oe_o,
   input wire logic overflow_flag_o,
   input wire logic overflow_irq_o,
   input wire logic [7:0] counter_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_load; $past(counter_o) == 8'hff && counter_o != 8'hff
      |-> counter_o == $past(reload_value_reg_i); endproperty
   a_load: assert property (p_load) else $error("bad reload");
   property p_pol; $past(counter_o) == 8'hff && counter_o != 8'hff
      |=> pwm_output_pin_o == (pwm_output_pin_oe_o & ~$past(pwm_output_polarity_i)); endproperty
   a_pol: assert property (p_pol) else $error("bad overflow level");
   property p_flag_set; $past(counter_o) == 8'hff && counter_o != 8'hff
      |-> overflow_flag_o; endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on overflow");
   property p_flag_hold; overflow_flag_o && !overflow_flag_clear_i |=> overflow_flag_o; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");
   property p_irq; overflow_irq_o == (overflow_flag_o && overflow_irq_enable_i); endproperty
   a_irq: assert property (p_irq) else $error("bad interrupt request");
   property p_hold; halt_i || !counter_enable_i |=> $stable(counter_o); endproperty
   a_hold: assert property (p_hold) else $error("counter moved while stopped");
   property p_oe; $past(resetn_i) |-> pwm_output_pin_oe_o == $past(pwm_output_enable_i)
      && (pwm_output_pin_o & ~pwm_output_pin_oe_o) == 4'h0; endproperty
   a_oe: assert property (p_oe) else $error("bad driver enable");
endmodule
bind arp_pwm_timer arp_pwm_timer_props u_props (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .halt_i(halt_i),
   .counter_enable_i(counter_enable_i),
   .overflow_irq_enable_i(overflow_irq_enable_i),
   .overflow_flag_clear_i(overflow_flag_clear_i),
   .reload_value_reg_i(reload_value_reg_i),
   .pwm_output_enable_i(pwm_output_enable_i),
   .pwm_output_polarity_i(pwm_output_polarity_i),
   .pwm_output_pin_o(pwm_output_pin_o),
   .pwm_output_pin_oe_o(pwm_output_pin_oe_o),
   .overflow_flag_o(overflow_flag_o),
   .overflow_irq_o(overflow_irq_o),
   .counter_o(counter_o)
);

// >>> sim/arp_pwm_timer_tb_top.sv
module arp_pwm_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, resetn_i = 0, halt_i = 0, external_count_clock_i = 0, event_mode_i = 0;
   logic counter_enable_i = 1, overflow_irq_enable_i = 1, overflow_flag_clear_i = 0, overflow_flag_o, overflow_irq_o;
   logic [7:0] reload_value_reg_i = 8'h00, counter_o, rv;
   logic [3:0] pwm_output_enable_i = 4'hf, pwm_output_polarity_i = 4'h0, pwm_output_pin_o, pwm_output_pin_oe_o, lvl, pv;
   logic [31:0] duty_compare_reg_i = 32'h0, dv;
   int checks = 0, n_mismatch = 0, c, n, k, j;
   int h [4];
   arp_pwm_timer dut (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .halt_i(halt_i),
      .external_count_clock_i(external_count_clock_i),
      .event_mode_i(event_mode_i),
      .counter_enable_i(counter_enable_i),
      .overflow_irq_enable_i(overflow_irq_enable_i),
      .overflow_flag_clear_i(overflow_flag_clear_i),
      .reload_value_reg_i(reload_value_reg_i),
      .pwm_output_enable_i(pwm_output_enable_i),
      .pwm_output_polarity_i(pwm_output_polarity_i),
      .duty_compare_reg_i(duty_compare_reg_i),
      .pwm_output_pin_o(pwm_output_pin_o),
      .pwm_output_pin_oe_o(pwm_output_pin_oe_o),
      .overflow_flag_o(overflow_flag_o),
      .overflow_irq_o(overflow_irq_o),
      .counter_o(counter_o)
   );
   arp_load_model u_load (.pin_i(pwm_output_pin_o), .oe_i(pwm_output_pin_oe_o), .level_o(lvl));
   always #50 clk_i = ~clk_i;
   task cmp(string s, logic [15:0] e, g);
      checks++;
      if (e !== g) begin
         n_mismatch++;
         $display("unexpected %s exp %0d got %0d", s, e, g);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // expected period in ticks for a reload value
   function automatic int exp_period(logic [7:0] r);
      return 256 - int'(r);
   endfunction
   // expected high cycles per period of one channel
   function automatic int exp_high(logic [7:0] r, d, logic p, en);
      if (!en) return 0;
      return p ? 256 - int'(d) : int'(d) - int'(r);
   endfunction
   // random compare value above the reload value
   function automatic logic [7:0] rand_duty(logic [7:0] r);
      return 8'(int'(r) + 1 + int'($urandom % (255 - int'(r))));
   endfunction
   // third flag closes one full measured period, checked on every channel only outside event mode
   task run(logic [7:0] r, logic [31:0] d, logic [3:0] p, e, logic ev);
      reload_value_reg_i = r;
      duty_compare_reg_i = d;
      pwm_output_polarity_i = p;
      pwm_output_enable_i = e;
      event_mode_i = ev;
      overflow_irq_enable_i = 1'($urandom);
      n = 0;
      for (k = 0; n < 3 && k < 9000; k++) begin
         @(negedge clk_i) external_count_clock_i = ev & k[2];
         if (overflow_flag_o === 1'b1) begin
            cmp("irq", 16'(overflow_irq_enable_i), 16'(overflow_irq_o));
            cmp("oe", 16'(e), 16'(pwm_output_pin_oe_o));
            if (n == 2) cmp("period", 16'(exp_period(r)), 16'(c));
            for (j = 0; j < 4; j++) begin
               if (n == 2 && !ev) cmp("high", 16'(exp_high(r, d[j*8 +: 8], p[j], e[j])), 16'(h[j]));
               h[j] = 0;
            end
            n++;
            c = 0;
         end
         overflow_flag_clear_i = overflow_flag_o;
         c += ev ? int'(k[2:0] == 3'h4) : 1;
         for (j = 0; j < 4; j++) h[j] += int'(lvl[j]);
      end
      cmp("flags", 16'h3, 16'(n));
      $display("test done reload %0d", r);
   endtask
   initial begin
      void'($urandom(32'h91b1));
      repeat (20) @(negedge clk_i);
      resetn_i = 1;
      run(8'h00, 32'hff80_40ff, 4'h1, 4'hf, 1'b0);
      repeat (4) begin
         rv = 8'($urandom % 200);
         for (j = 0; j < 4; j++) dv[j*8 +: 8] = rand_duty(rv);
         run(rv, dv, 4'($urandom), 4'($urandom), 1'b0);
      end
      run(8'hfe, 32'hffff_ffff, 4'h0, 4'hf, 1'b1);
      // counter enable low: external edges no longer move the counter
      counter_enable_i = 0;
      rv = counter_o;
      for (k = 0; k < 32; k++) @(negedge clk_i) external_count_clock_i = k[2];
      cmp("disabled", 16'(rv), 16'(counter_o));
      $display("test done disable");
      // halt with the internal clock selected: counter and pins freeze
      event_mode_i = 0;
      counter_enable_i = 1;
      halt_i = 1;
      @(negedge clk_i) rv = counter_o;
      pv = pwm_output_pin_o;
      repeat (5) @(negedge clk_i);
      cmp("halt", 16'(rv), 16'(counter_o));
      cmp("halt pins", 16'(pv), 16'(pwm_output_pin_o));
      halt_i = 0;
      @(negedge clk_i);
      cmp("resume", 16'(rv == 8'hff ? reload_value_reg_i : 8'(rv + 8'h01)), 16'(counter_o));
      $display("test done halt");
      // reset in mid-run returns every output to its reset value
      resetn_i = 0;
      @(negedge clk_i);
      cmp("reset counter", 16'h0, 16'(counter_o));
      cmp("reset outputs", 16'h0, 16'({overflow_flag_o, pwm_output_pin_o, pwm_output_pin_oe_o}));
      resetn_i = 1;
      $display("test done reset");
      print_verdict;
   end
   // watchdog: nine tests of at most about 2100 cycles each fit well inside 30000 cycles
   initial begin
      #3000000;
      n_mismatch++;
      print_verdict;
   end
endmodule
